// >>> hdl/eight_pin_gpio_control.sv
// APB-reached control word for eight general-purpose pins.
// Assumes pin inputs synchronous to pclk and power-event enables from the
// downstream port logic; the pad cell resolves the pin from level and oe_n.
// A transfer whose setup edge falls in a frozen cycle is answered one cycle late.
//
// Local design decision: the APB slave port.
module eight_pin_gpio_control #(
	parameter bit UPSTREAM = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pin_ctrl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pin_ctrl_pkg::PINS-1:0] pin_in,
	output pin_ctrl_pkg::pad_drive_t pad,
	input wire logic pme_en_port1,
	input wire logic pme_en_port2
);

	logic [pin_ctrl_pkg::PINS-1:0] pin_sample;
	logic [pin_ctrl_pkg::PINS-1:0] dir;
	logic [pin_ctrl_pkg::PINS-1:0] out_val;
	logic [pin_ctrl_pkg::PINS-1:0] blocked;
	logic [pin_ctrl_pkg::PINS-1:0] next_oe_n;
	logic [pin_ctrl_pkg::PINS-1:0] next_level;
	logic refused;
	logic loaded;
	logic hit;
	logic setup;
	logic access;
	pin_ctrl_pkg::pin_word_t read_word;
	pin_ctrl_pkg::pin_word_t wimg;

	// Byte lane that carries pin k
	function automatic logic lane_on(input logic [3:0] strb, input int k);
		lane_on = strb[k/2];
	endfunction : lane_on

	// Address decode; downstream instances never hit, so they answer with an error
	assign hit = UPSTREAM && (paddr[pin_ctrl_pkg::ADDR_W-1:2] ==
		pin_ctrl_pkg::PIN_CTRL_OFFSET[pin_ctrl_pkg::ADDR_W-1:2]);
	assign setup = psel && !penable && clk_en;
	assign access = psel && penable && clk_en;
	assign wimg = pwdata;

	// Zero wait states once read data is held; low while the clock enable freezes us.
	// Answering before the capture would hand out stale data after a frozen setup
	assign pready = access && loaded;
	assign pslverr = pready && refused;

	// Read image, reserved bits forced low
	always_comb begin
		for (int k = 0; k < pin_ctrl_pkg::PINS; k++) begin
			read_word[k].in_val = pin_sample[k];
			read_word[k].dir = dir[k];
			read_word[k].out_val = out_val[k];
			read_word[k].rsvd = 1'b0;
		end
	end

	// Pin level capture; one flop, inputs are already synchronous
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sample <= pin_ctrl_pkg::IN_RESET;
		end else if (clk_en) begin
			pin_sample <= pin_in;
		end
	end

	// Direction and output value bits, written at the access edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir <= pin_ctrl_pkg::DIR_RESET;
			out_val <= pin_ctrl_pkg::OUT_RESET;
		end else if (pready && pwrite && hit) begin
			for (int k = 0; k < pin_ctrl_pkg::PINS; k++) begin
				if (lane_on(pstrb, k)) begin
					dir[k] <= wimg[k].dir;
					out_val[k] <= wimg[k].out_val;
				end
			end
		end
	end

	// Transfer under way with its data held; set by its first enabled
	// edge, cleared by its completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded <= 1'b0;
		end else if (clk_en) begin
			loaded <= psel && !pready;
		end
	end

	// Read data and error captured once per transfer, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			refused <= 1'b0;
		end else if (psel && clk_en && !loaded) begin
			prdata <= (hit && !pwrite) ? 32'(read_word) : 32'h0000_0000;
			refused <= !hit;
		end
	end

	// Pins 0 and 1 are handed to the power-event logic while it is enabled
	always_comb begin
		blocked = '0;
		blocked[0] = pme_en_port1;
		blocked[1] = pme_en_port2;
		next_oe_n = ~(dir & ~blocked);
		next_level = out_val & dir & ~blocked;
	end

	// Registered pad drive; released after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad.oe_n <= pin_ctrl_pkg::OE_N_RESET;
			pad.level <= 8'h00;
		end else if (clk_en) begin
			pad.oe_n <= next_oe_n;
			pad.level <= next_level;
		end
	end

	// Checks, all on pclk and quiet in reset
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Input bits reflect the pins one edge later
	property p_input_sample;
		clk_en |=> (pin_sample == $past(pin_in));
	endproperty
	a_input_sample: assert property (p_input_sample)
		else $error("input bits do not follow the pins");

	// Read returns the sampled level in every input bit
	property p_read_inputs;
		(setup && hit && !pwrite) |=> (prdata & 32'h1111_1111) ==
			($past(32'(read_word)) & 32'h1111_1111);
	endproperty
	a_read_inputs: assert property (p_read_inputs)
		else $error("read data input bits wrong");

	// Full-word write lands in direction bits at the access edge
	property p_dir_write;
		(pready && pwrite && hit && pstrb == 4'hf) |=>
			(dir[7] == $past(pwdata[29])) && (dir[0] == $past(pwdata[1]));
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("direction write lost");

	// A write with no lanes leaves the word alone
	property p_no_lane;
		(access && pwrite && pstrb == 4'h0) |=> $stable(dir) && $stable(out_val);
	endproperty
	a_no_lane: assert property (p_no_lane)
		else $error("write with empty strobe changed state");

	// Output pin 7 drives the stored value
	property p_drive;
		(clk_en && dir[7]) |=> !pad.oe_n[7] && (pad.level[7] == $past(out_val[7]));
	endproperty
	a_drive: assert property (p_drive)
		else $error("output pin not driven with stored value");

	// Pin 0 released while port 1 power-event is enabled
	property p_pme1;
		(clk_en && pme_en_port1) |=> pad.oe_n[0];
	endproperty
	a_pme1: assert property (p_pme1)
		else $error("pin 0 driven during power event");

	// Pin 1 released while port 2 power-event is enabled
	property p_pme2;
		(clk_en && pme_en_port2) |=> pad.oe_n[1] && !pad.level[1];
	endproperty
	a_pme2: assert property (p_pme2)
		else $error("pin 1 driven during power event");

	// Reserved bits always read zero
	property p_rsvd;
		pready |-> ((prdata & pin_ctrl_pkg::RSVD_MASK) == 32'h0000_0000);
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bit read as one");

	// Misses and downstream instances answer with an error
	property p_unmapped;
		(setup && !hit) ##1 (psel && penable && clk_en) |-> pslverr && prdata == 0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");

	// Pin 7 direction sits at bit 29
	property p_layout;
		(setup && hit && !pwrite) |=> (prdata[29] == $past(dir[7])) &&
			(prdata[30] == $past(out_val[7]));
	endproperty
	a_layout: assert property (p_layout)
		else $error("pin 7 fields misplaced");

	// Inputs are never driven
	property p_release;
		(clk_en && dir == 8'h00) |=> (pad.oe_n == 8'hff) && (pad.level == 8'h00);
	endproperty
	a_release: assert property (p_release)
		else $error("input pin driven");

	// Frozen clock enable holds the pad drive, the read data and the direction bits
	property p_freeze;
		!clk_en |=> $stable(pad) && $stable(prdata) && $stable(dir);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved with clock enable low");

	// Full-word write lands in output value bits at the completing edge
	property p_out_write;
		(pready && pwrite && hit && pstrb == 4'hf) |=>
			(out_val[7] == $past(pwdata[30])) && (out_val[0] == $past(pwdata[2]));
	endproperty
	a_out_write: assert property (p_out_write)
		else $error("output value write lost");

	// Lane 0 alone leaves pins 2 to 7 untouched
	property p_lane_keep;
		(pready && pwrite && hit && pstrb == 4'h1) |=>
			(dir[7:2] == $past(dir[7:2])) && (out_val[7:2] == $past(out_val[7:2]));
	endproperty
	a_lane_keep: assert property (p_lane_keep)
		else $error("write reached a pin outside its lane");

	// Refused writes change nothing
	property p_miss_write;
		(pready && pwrite && !hit) |=> $stable(dir) && $stable(out_val);
	endproperty
	a_miss_write: assert property (p_miss_write)
		else $error("refused write changed state");

	// Pin 0 carries no level while port 1 power-event is enabled
	property p_pme1_level;
		(clk_en && pme_en_port1) |=> !pad.level[0];
	endproperty
	a_pme1_level: assert property (p_pme1_level)
		else $error("pin 0 level leaked during power event");

	// Pin 1 driven again once port 2 power-event is disabled
	property p_pme2_back;
		(clk_en && !pme_en_port2 && dir[1]) |=>
			!pad.oe_n[1] && (pad.level[1] == $past(out_val[1]));
	endproperty
	a_pme2_back: assert property (p_pme2_back)
		else $error("pin 1 not driven after power event");

	// No answer while frozen
	property p_stall;
		!clk_en |-> !pready;
	endproperty
	a_stall: assert property (p_stall)
		else $error("answer given with clock enable low");

	// A late capture answers at the very next enabled access cycle
	property p_late_ready;
		(access && !pready) ##1 access |-> pready;
	endproperty
	a_late_ready: assert property (p_late_ready)
		else $error("access not answered after late capture");

	// A released pin never carries a level
	property p_level_low;
		(pad.level & pad.oe_n) == 8'h00;
	endproperty
	a_level_low: assert property (p_level_low)
		else $error("level present on released pin");

	// Main scenarios
	property p_cov_write;
		access && pwrite && hit;
	endproperty
	c_cov_write: cover property (p_cov_write);

	property p_cov_read;
		access && !pwrite && hit;
	endproperty
	c_cov_read: cover property (p_cov_read);

	property p_cov_err;
		pslverr;
	endproperty
	c_cov_err: cover property (p_cov_err);

	property p_cov_pme;
		dir[0] && pme_en_port1 ##1 dir[0] && !pme_en_port1;
	endproperty
	c_cov_pme: cover property (p_cov_pme);

	property p_cov_stall;
		access && !pready;
	endproperty
	c_cov_stall: cover property (p_cov_stall);

endmodule : eight_pin_gpio_control

// >>> inc/pin_ctrl_pkg.sv
// Constants and types for the eight-pin general-purpose control word.
// Assumes an APB slave with 32-bit data and a 12-bit configuration offset.
package pin_ctrl_pkg;

	localparam int ADDR_W = 12;
	localparam int PINS = 8;

	// Word location in configuration space
	localparam logic [ADDR_W-1:0] PIN_CTRL_OFFSET = 12'h0b8;

	// Values after reset
	localparam logic [PINS-1:0] IN_RESET = 8'hff;
	localparam logic [PINS-1:0] DIR_RESET = 8'h00;
	localparam logic [PINS-1:0] OUT_RESET = 8'h00;
	localparam logic [PINS-1:0] OE_N_RESET = 8'hff;

	// Reserved bit of every slice
	localparam logic [31:0] RSVD_MASK = 32'h8888_8888;

	// One four-bit slice, lowest field at bit 4n
	typedef struct packed {
		logic rsvd;
		logic out_val;
		logic dir;
		logic in_val;
	} pin_slice_t;

	typedef pin_slice_t [PINS-1:0] pin_word_t;

	// Pin-side bundle toward the pads
	typedef struct packed {
		logic [PINS-1:0] level;
		logic [PINS-1:0] oe_n;
	} pad_drive_t;

endpackage : pin_ctrl_pkg

// >>> tb/pin_board.sv
// Board model of the eight general-purpose pins.
// Assumes the pad bundle of the control block and one board level per pin.
module pin_board (
	input wire pin_ctrl_pkg::pad_drive_t pad,
	input wire logic [pin_ctrl_pkg::PINS-1:0] ext,
	output logic [pin_ctrl_pkg::PINS-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Driven pins loop back; released pins show the board level, not a stale drive
	always_comb begin
		for (int n = 0; n < pin_ctrl_pkg::PINS; n++) begin
			pin_in[n] = pad.oe_n[n] ? ext[n] : pad.level[n];
		end
	end
endmodule : pin_board

// >>> tb/test_eight_pin_gpio_control.sv
// Self-checking bench for the eight-pin control word.
// Assumes an APB slave that may stall on pready and the board model on the pin side.
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_eight_pin_gpio_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] OFS = pin_ctrl_pkg::PIN_CTRL_OFFSET;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err, pme1 = 0, pme2 = 0, clk_en = 1;
	logic [3:0] strb = 4'hf;
	logic [7:0] pin_in, ext = 8'hff;
	pin_ctrl_pkg::pad_drive_t pad;
	int err_total = 0, checks = 0;
	// Clock; strobe and clock enable are set by the scenarios
	always #5 pclk = ~pclk;
	eight_pin_gpio_control u_eight_pin_gpio_control (.pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pad(pad), .pme_en_port1(pme1), .pme_en_port2(pme2));
	pin_board u_pin_board (.pad(pad), .ext(ext), .pin_in(pin_in));
	// One APB transfer; waits on pready, the watchdog ends a hang
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Expected input bits placed at bit 4n
	function automatic logic [31:0] ins(input logic [7:0] v);
		logic [31:0] w;
		w = '0;
		for (int n = 0; n < 8; n++) w[4*n] = v[n];
		return w;
	endfunction : ins
	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask : settle
	task automatic t_reset();
		apb(1'b0, OFS, '0);
		`CHK("reset word", 32'h1111_1111, rd)
		`CHK("reset pad", 16'h00ff, pad)
	endtask : t_reset
	// Reserved bits written as ones must read back zero
	task automatic t_out_high();
		apb(1'b1, OFS, 32'hffff_ffff);
		settle();
		apb(1'b0, OFS, '0);
		`CHK("word high", 32'h7777_7777, rd)
		`CHK("pad high", 16'hff00, pad)
	endtask : t_out_high
	// Power-event enables release pins 0 and 1 only
	task automatic t_pme();
		pme1 <= 1'b1;
		pme2 <= 1'b1;
		settle();
		`CHK("pad both", 16'hfc03, pad)
		pme2 <= 1'b0;
		settle();
		`CHK("pad port1", 16'hfe01, pad)
		pme1 <= 1'b0;
		settle();
	endtask : t_pme
	task automatic t_out_low();
		apb(1'b1, OFS, 32'h2222_2222);
		settle();
		apb(1'b0, OFS, '0);
		`CHK("word low", 32'h2222_2222, rd)
		`CHK("pin7 dir", 1'b1, rd[29])
		`CHK("pad low", 16'h0000, pad)
	endtask : t_out_low
	// Stored output ones must not reach released pins
	task automatic t_input();
		ext <= 8'h5a;
		apb(1'b1, OFS, 32'h4444_4444);
		settle();
		apb(1'b0, OFS, '0);
		`CHK("word in", ins(8'h5a) | 32'h4444_4444, rd)
		`CHK("pad in", 16'h00ff, pad)
	endtask : t_input
	task automatic t_miss();
		apb(1'b1, 12'h0bc, 32'h2222_2222);
		`CHK("miss err", 1'b1, err)
		apb(1'b0, 12'h0bc, '0);
		`CHK("miss data", 32'h0000_0000, rd)
		`CHK("miss pad", 16'h00ff, pad)
	endtask : t_miss
	// Lane 0 reaches pins 0 and 1 only, an empty strobe nothing
	task automatic t_lanes();
		strb <= 4'h1;
		apb(1'b1, OFS, 32'hffff_ffff);
		strb <= 4'h0;
		apb(1'b1, OFS, 32'h0000_0000);
		strb <= 4'hf;
		settle();
		apb(1'b0, OFS, '0);
		`CHK("word lanes", 32'h4545_5477, rd)
		`CHK("pad lanes", 16'h03fc, pad)
	endtask : t_lanes
	// Frozen clock enable across a setup edge; the read must still be fresh
	task automatic t_freeze();
		clk_en <= 1'b0;
		pme1 <= 1'b1;
		settle();
		`CHK("pad frozen", 16'h03fc, pad)
		fork
			apb(1'b0, OFS, '0);
			begin
				settle();
				clk_en <= 1'b1;
			end
		join
		`CHK("late read", 32'h4545_5477, rd)
		`CHK("late pad", 16'h02fd, pad)
		pme1 <= 1'b0;
		settle();
	endtask : t_freeze
	task automatic end_sim();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_out_high();
		t_pme();
		t_out_low();
		t_input();
		t_miss();
		t_lanes();
		t_freeze();
		end_sim();
	end
	// Watchdog well beyond the roughly 80 cycles the tests need
	initial begin
		#20000;
		err_total++;
		end_sim();
	end
endmodule : test_eight_pin_gpio_control
